//--- verilog/tcmp_regs.vh
`ifndef TCMP_REGS_VH
`define TCMP_REGS_VH
// Register byte offsets
`define TCMP_CTRL_OFF     4'h0
`define TCMP_COUNT_OFF    4'h4
`define TCMP_CMP_OFF      4'h8
`define TCMP_STAT_OFF     4'hc
// Control register fields
`define TCMP_CTRL_CS_LO   0
`define TCMP_CTRL_CS_HI   2
`define TCMP_CTRL_WGM_LO  3
`define TCMP_CTRL_WGM_HI  4
`define TCMP_CTRL_COM_LO  5
`define TCMP_CTRL_COM_HI  6
`define TCMP_CTRL_FOC     7
`define TCMP_CTRL_DDR     8
// Status register fields
`define TCMP_STAT_TOV     0
`define TCMP_STAT_OCF     1
`define TCMP_STAT_OCS     2
// Waveform modes
`define TCMP_WGM_NORMAL   2'h0
`define TCMP_WGM_PCPWM    2'h1
`define TCMP_WGM_CTC      2'h2
`define TCMP_WGM_FPWM     2'h3
// Compare output modes
`define TCMP_COM_NONE     2'h0
`define TCMP_COM_TOGGLE   2'h1
`define TCMP_COM_CLEAR    2'h2
`define TCMP_COM_SET      2'h3
// Reset values, count top and response codes
`define TCMP_CTRL_RST     9'h000
`define TCMP_BYTE_RST     8'h00
`define TCMP_MAX          8'hff
`define TCMP_BRESP_OK     2'h0
`define TCMP_BRESP_SLVERR 2'h2
`endif

//--- verilog/tcmp_wavegen.v
`timescale 1ns/1ns
`default_nettype none
`include "tcmp_regs.vh"
module tcmp_wavegen (
  // Clock and reset
  input  wire       CLK,
  input  wire       RST_B,
  // Control
  input  wire [1:0] COM,
  input  wire [1:0] WGM,
  input  wire       MATCH,
  input  wire       FORCE,
  input  wire       BOTTOM,
  input  wire       DOWN,
  // Output state
  output reg        OCS
);
  reg  ocs_d;
  wire pwm = (WGM == `TCMP_WGM_PCPWM) || (WGM == `TCMP_WGM_FPWM);
  always @* begin
    ocs_d = OCS;
    if (!pwm) begin
      if (MATCH || FORCE) begin
        case (COM)
          `TCMP_COM_TOGGLE: ocs_d = ~OCS;
          `TCMP_COM_CLEAR:  ocs_d = 1'b0;
          `TCMP_COM_SET:    ocs_d = 1'b1;
          default:          ocs_d = OCS;
        endcase
      end
    end else if (COM[1]) begin
      if (WGM == `TCMP_WGM_FPWM) begin
        if (MATCH)
          ocs_d = COM[0];
        else if (BOTTOM)
          ocs_d = ~COM[0];
      end else if (MATCH) begin
        ocs_d = DOWN ? ~COM[0] : COM[0];
      end
    end else if (COM == `TCMP_COM_TOGGLE && MATCH && WGM == `TCMP_WGM_FPWM) begin
      ocs_d = ~OCS;
    end
  end
  // COM sampled only at match, force or fast PWM bottom, so a write alone never moves the state
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B)
      OCS <= 1'b0;
    else
      OCS <= ocs_d;
  end
endmodule // tcmp_wavegen
`default_nettype wire

//--- verilog/tcmp_timer.v
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "tcmp_regs.vh"
module tcmp_timer (
  // Clock and reset
  input  wire        CLK,
  input  wire        RST_B,
  // AXI4-Lite write address
  input  wire [3:0]  S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output wire        S_AXI_AWREADY,
  // AXI4-Lite write data
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output wire        S_AXI_WREADY,
  // AXI4-Lite write response
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  // AXI4-Lite read address
  input  wire [3:0]  S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output wire        S_AXI_ARREADY,
  // AXI4-Lite read data
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  // Port pin
  input  wire        PORT_OUT,
  output wire        PIN_OUT,
  output wire        PIN_OE
);
  reg  [8:0] ctrl_q;
  reg  [7:0] count_q;
  reg  [7:0] count_d;
  reg  [7:0] cmp_q;
  reg        tov_q;
  reg        ocf_q;
  reg        down_q;
  reg        down_d;
  reg        blk_q;
  reg        match_q;
  reg        aw_q;
  reg        w_q;
  reg  [3:0] awaddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0] wstrb_q;
  wire       ocs;

  wire [2:0] cs  = ctrl_q[`TCMP_CTRL_CS_HI:`TCMP_CTRL_CS_LO];
  wire [1:0] wgm = ctrl_q[`TCMP_CTRL_WGM_HI:`TCMP_CTRL_WGM_LO];
  wire [1:0] com = ctrl_q[`TCMP_CTRL_COM_HI:`TCMP_CTRL_COM_LO];
  wire       ddr = ctrl_q[`TCMP_CTRL_DDR];
  wire       run = (cs != 3'h0);

  // Write channel: address and data latched separately, either order
  wire       wr_go  = aw_q && w_q && !S_AXI_BVALID;
  wire       wr_ctl = wr_go && awaddr_q == `TCMP_CTRL_OFF;
  wire       wr_cnt = wr_go && awaddr_q == `TCMP_COUNT_OFF && wstrb_q[0];
  wire       wr_cmp = wr_go && awaddr_q == `TCMP_CMP_OFF && wstrb_q[0];
  wire       wr_sts = wr_go && awaddr_q == `TCMP_STAT_OFF && wstrb_q[0];
  wire       mapped = (awaddr_q == `TCMP_CTRL_OFF) || (awaddr_q == `TCMP_COUNT_OFF)
                   || (awaddr_q == `TCMP_CMP_OFF) || (awaddr_q == `TCMP_STAT_OFF);
  wire       pwm    = (wgm == `TCMP_WGM_PCPWM) || (wgm == `TCMP_WGM_FPWM);
  // Strobe written together with its mode must use the new mode bits
  wire [1:0] wgm_w   = wdata_q[`TCMP_CTRL_WGM_HI:`TCMP_CTRL_WGM_LO];
  wire       pwm_w   = (wgm_w == `TCMP_WGM_PCPWM) || (wgm_w == `TCMP_WGM_FPWM);
  wire       force_s = wr_ctl && wstrb_q[0] && wdata_q[`TCMP_CTRL_FOC] && !pwm_w;
  wire [1:0] com_in  = force_s ? wdata_q[`TCMP_CTRL_COM_HI:`TCMP_CTRL_COM_LO] : com;
  wire [1:0] wgm_in  = force_s ? wgm_w : wgm;

  assign S_AXI_AWREADY = !aw_q;
  assign S_AXI_WREADY  = !w_q;
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  // Comparator; a count write blocks the following cycle's match
  wire       equal   = (count_q == cmp_q);
  wire       match   = equal && !blk_q && !wr_cnt;
  wire       at_max  = (count_q == `TCMP_MAX);
  wire       bottom  = run && (count_d == `TCMP_BYTE_RST) && (count_q != `TCMP_BYTE_RST);

  // Sequence chosen by waveform mode only
  always @* begin
    count_d = count_q;
    down_d  = down_q;
    if (wr_cnt) begin
      count_d = wdata_q[7:0];
    end else if (run) begin
      case (wgm)
        `TCMP_WGM_NORMAL: count_d = count_q + 8'h01;
        `TCMP_WGM_CTC:    count_d = equal ? `TCMP_BYTE_RST : count_q + 8'h01;
        `TCMP_WGM_FPWM:   count_d = count_q + 8'h01;
        `TCMP_WGM_PCPWM: begin
          if (at_max)
            down_d = 1'b1;
          else if (count_q == `TCMP_BYTE_RST)
            down_d = 1'b0;
          count_d = (down_d) ? count_q - 8'h01 : count_q + 8'h01;
        end
        default:          count_d = count_q;
      endcase
    end
  end

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_q  <= `TCMP_CTRL_RST;
      count_q <= `TCMP_BYTE_RST;
      cmp_q   <= `TCMP_BYTE_RST;
      tov_q   <= 1'b0;
      ocf_q   <= 1'b0;
      down_q  <= 1'b0;
      blk_q   <= 1'b0;
      match_q <= 1'b0;
    end else begin
      count_q <= count_d;
      down_q  <= down_d;
      blk_q   <= wr_cnt;
      match_q <= match && run;
      if (wr_ctl) begin
        if (wstrb_q[0])
          ctrl_q[6:0] <= wdata_q[6:0];
        if (wstrb_q[1])
          ctrl_q[`TCMP_CTRL_DDR] <= wdata_q[`TCMP_CTRL_DDR];
      end
      if (wr_cmp)
        cmp_q <= wdata_q[7:0];
      // Set wins over a same-cycle write-one clear
      if (run && !wr_cnt && count_d == `TCMP_BYTE_RST && count_q != `TCMP_BYTE_RST)
        tov_q <= 1'b1;
      else if (wr_sts && wdata_q[`TCMP_STAT_TOV])
        tov_q <= 1'b0;
      if (match_q)
        ocf_q <= 1'b1;
      else if (wr_sts && wdata_q[`TCMP_STAT_OCF])
        ocf_q <= 1'b0;
    end
  end

  // AXI write path
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_q         <= 1'b0;
      w_q          <= 1'b0;
      awaddr_q     <= 4'h0;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `TCMP_BRESP_OK;
    end else begin
      if (S_AXI_AWVALID && !aw_q) begin
        aw_q     <= 1'b1;
        awaddr_q <= {S_AXI_AWADDR[3:2], 2'b00};
      end
      if (S_AXI_WVALID && !w_q) begin
        w_q     <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= mapped ? `TCMP_BRESP_OK : `TCMP_BRESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        aw_q         <= 1'b0;
        w_q          <= 1'b0;
      end
    end
  end

  // AXI read path
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= `TCMP_BRESP_OK;
    end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP  <= `TCMP_BRESP_OK;
      case ({S_AXI_ARADDR[3:2], 2'b00})
        `TCMP_CTRL_OFF:  S_AXI_RDATA <= {23'h0, ctrl_q[8], 1'b0, ctrl_q[6:0]};
        `TCMP_COUNT_OFF: S_AXI_RDATA <= {24'h0, count_q};
        `TCMP_CMP_OFF:   S_AXI_RDATA <= {24'h0, cmp_q};
        `TCMP_STAT_OFF:  S_AXI_RDATA <= {29'h0, ocs, ocf_q, tov_q};
        default: begin
          S_AXI_RDATA <= 32'h0000_0000;
          S_AXI_RRESP <= `TCMP_BRESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  tcmp_wavegen u_wavegen (
    .CLK    (CLK),
    .RST_B  (RST_B),
    .COM    (com_in),
    .WGM    (wgm_in),
    .MATCH  (match && run),
    .FORCE  (force_s),
    .BOTTOM (bottom),
    .DOWN   (down_q),
    .OCS    (ocs)
  );

  // Override by compare mode alone; direction stays with the control register DDR bit
  assign PIN_OUT = (com != `TCMP_COM_NONE) ? ocs : PORT_OUT;
  assign PIN_OE  = ddr;
endmodule // tcmp_timer
`default_nettype wire

//--- verif/tcmp_checker.sv
`timescale 1ns/1ns
`default_nettype none
module tcmp_checker (
  // Watched top ports
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic        PIN_OE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  rst_quiet_a: assert property (disable iff (1'b0) !RST_B |-> !PIN_OE && !S_AXI_BVALID && !S_AXI_RVALID)
    else $error("outputs active in reset");
  wr_resp_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:3] S_AXI_BVALID)
    else $error("write not answered");
  b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("bvalid dropped");
  r_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  rd_resp_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read late");
  ar_busy_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("arready while busy");
  w_busy_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write ready while busy");
  oe_write_a: assert property ($changed(PIN_OE) |-> $rose(S_AXI_BVALID))
    else $error("pin enable moved alone");
endmodule // tcmp_checker
bind tcmp_timer tcmp_checker u_chk (.CLK(CLK), .RST_B(RST_B), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .PIN_OE(PIN_OE));
`default_nettype wire

//--- verif/tcmp_port_model.sv
`timescale 1ns/1ns
`default_nettype none
module tcmp_port_model (
  input  wire logic clk,
  input  wire logic nxt,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output var  logic port_out,
  output wire logic pin_lvl
);
  initial port_out = 1'b0;
  always @(posedge clk) port_out <= nxt;
  // Released pin floats up through the pull-up
  assign pin_lvl = pin_oe ? pin_out : 1'b1;
endmodule // tcmp_port_model
`default_nettype wire

//--- verif/tb_timer_compare_output_normal_mode.sv
`timescale 1ns/1ns
`default_nettype none
`include "tcmp_regs.vh"
module tb_timer_compare_output_normal_mode;
  logic        clk = 0, rst_b = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, nxt = 0, ocs = 0;
  logic [3:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0, lf = 32'h42f9517a, eq[$];
  logic [7:0]  cnt;
  wire  [31:0] rd;
  wire         awr, wr_r, bv, arr, rv, pin_out, pin_oe, port_out, pin_lvl;
  int          n_fail = 0, samples_checked = 0, cyc = 0, t0;
  int          cms[4] = '{3, 2, 1, 0};
  tcmp_timer DUT (.CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'h3), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_r), .S_AXI_BRESP(),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rd), .S_AXI_RRESP(), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .PORT_OUT(port_out),
    .PIN_OUT(pin_out), .PIN_OE(pin_oe));
  tcmp_port_model u_port (.clk(clk), .nxt(nxt), .pin_out(pin_out), .pin_oe(pin_oe), .port_out(port_out),
    .pin_lvl(pin_lvl));
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      report_and_stop;
    end
  end
  always @(posedge clk)
    if (rv && rry) chk(eq.pop_front(), rd);
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] ctl(int cs, int wg, int cm, int fc, int dd);
    return 32'({dd[0], fc[0], cm[1:0], wg[1:0], cs[2:0]});
  endfunction
  task automatic chk(logic [31:0] e, logic [31:0] a);
    samples_checked++;
    if (a !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    bit done;
    done = 0;
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bry <= 1;
    do begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wr_r) wv <= 0;
      if (bv) begin
        done = 1;
      end
    end while (!done);
  endtask
  task automatic rdq(logic [3:0] a, logic [31:0] e);
    eq.push_back(e);
    ara <= a;
    arv <= 1;
    rry <= 1;
    do @(posedge clk); while (!arr);
    arv <= 0;
    do @(posedge clk); while (!rv);
  endtask
  task automatic report_and_stop;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    for (int i = 0; i < 16; i += 4) rdq(4'(i), 0);
    $display("reset values done");
    // Timer stopped, so only the strobe can move the state
    foreach (cms[i]) begin
      if (cms[i] == 1) ocs = !ocs;
      else if (cms[i] != 0) ocs = cms[i][0];
      wr(`TCMP_CTRL_OFF, ctl(0, 0, cms[i], 1, 0));
      rdq(`TCMP_STAT_OFF, 32'(ocs) << 2);
    end
    wr(`TCMP_CTRL_OFF, ctl(0, 1, 2, 1, 0));
    rdq(`TCMP_STAT_OFF, 32'(ocs) << 2);
    rdq(`TCMP_COUNT_OFF, 0);
    $display("force done");
    ocs = 0;
    for (int i = 0; i < 2; i++) begin
      wr(`TCMP_CTRL_OFF, ctl(0, 2, 2 - 2 * i, 1 - i, 1));
      repeat (4) begin
        nxt <= lf[0];
        lf = lfsr(lf);
        repeat (2) @(posedge clk);
        chk(i == 0 ? 32'h0 : 32'(port_out), 32'(pin_lvl));
      end
    end
    $display("pin override done");
    wr(`TCMP_CMP_OFF, 2);
    wr(`TCMP_COUNT_OFF, 'hfd);
    wr(`TCMP_CTRL_OFF, ctl(1, 0, 1, 0, 1));
    t0 = cyc;
    repeat (10) @(posedge clk);
    wr(`TCMP_CTRL_OFF, ctl(0, 0, 1, 0, 1));
    cnt = 8'hfd + 8'(cyc - t0);
    rdq(`TCMP_COUNT_OFF, 32'(cnt));
    rdq(`TCMP_STAT_OFF, 7);
    wr(`TCMP_STAT_OFF, 3);
    rdq(`TCMP_STAT_OFF, 4);
    $display("normal count done");
    wr(`TCMP_CTRL_OFF, ctl(1, 0, 1, 0, 1));
    wr(`TCMP_COUNT_OFF, 2);
    t0 = cyc;
    repeat (3) @(posedge clk);
    wr(`TCMP_CTRL_OFF, ctl(0, 0, 1, 0, 1));
    cnt = 8'h02 + 8'(cyc - t0);
    rdq(`TCMP_COUNT_OFF, 32'(cnt));
    rdq(`TCMP_STAT_OFF, 4);
    $display("match blocking done");
    @(posedge clk);
    report_and_stop;
  end
endmodule // tb_timer_compare_output_normal_mode
`default_nettype wire
